// file: common/fcd_regs_regs.svh
`ifndef FCD_REGS_REGS_SVH
`define FCD_REGS_REGS_SVH

// Build-time detector selection codes
`define FCD_SEL_OFF    2'h0
`define FCD_SEL_32     2'h1
`define FCD_SEL_22     2'h2
`define FCD_SEL_BOTH   2'h3

// Metric thresholds (below means match or comb free)
`define FCD_MATCH_THR  16'h0040
`define FCD_COMB_THR   16'h0040

// Cadence counts
`define FCD_GAP32      3'h4
`define FCD_GAP_MAX    3'h7
`define FCD_PER32      2'h2
`define FCD_MISS32     4'hb
`define FCD_LOCK22     3'h6
`define FCD_UNLOCK22   2'h3
`define FCD_SEEN_FULL  2'h2
`endif

// file: common/fcd_pkg.sv
package fcd_pkg;

  typedef enum logic [1:0] {
    FCD_PASS,
    FCD_WEAVE_CUR,
    FCD_WEAVE_PAST
  } fcd_mode_t;

  // One field summary from the upstream field source
  typedef struct packed {
    logic        parity;
    logic [15:0] diff;
    logic [15:0] comb;
  } fcd_field_t;

  // One decision for the frame output path
  typedef struct packed {
    fcd_mode_t mode;
    logic      lock32;
    logic      lock22;
    logic      parity;
  } fcd_dec_t;

  typedef struct packed {
    logic [1:0] seen;
    logic       have_m;
    logic [2:0] gap;
    logic [1:0] per;
    logic [3:0] miss;
    logic       lock32;
    logic       prev_cf;
    logic [2:0] cad;
    logic [1:0] nc;
    logic       lock22;
    fcd_dec_t   e0;
    fcd_dec_t   e1;
    logic       v0;
    logic       v1;
    logic       rdy;
  } fcd_state_t;

endpackage : fcd_pkg

// file: hdl/fcd_top.sv
`timescale 1ns/100ps
`include "fcd_regs_regs.svh"

module fcd_top #(
  parameter logic [1:0] CADENCE_SEL = `FCD_SEL_BOTH
) (
  input  wire logic               clk_sys,
  input  wire logic               rstn,
  input  wire logic               in_valid,
  input  wire fcd_pkg::fcd_field_t in_field,
  output      logic               in_ready,
  output      logic               out_valid,
  input  wire logic               out_ready,
  output      fcd_pkg::fcd_dec_t  out_dec,
  output      logic               lock32,
  output      logic               lock22
);

  localparam logic EN32 = (CADENCE_SEL == `FCD_SEL_32) ||
                          (CADENCE_SEL == `FCD_SEL_BOTH);
  localparam logic EN22 = (CADENCE_SEL == `FCD_SEL_22) ||
                          (CADENCE_SEL == `FCD_SEL_BOTH);

  fcd_pkg::fcd_state_t q;
  fcd_pkg::fcd_state_t d;
  fcd_pkg::fcd_dec_t   nd;
  logic                acc;
  logic                pop;
  logic                match;
  logic                cfree;
  logic                cadf;
  logic [1:0]          per_n;

  always_comb begin
    d     = q;
    nd    = '0;
    per_n = q.per;
    acc   = in_valid && q.rdy;
    pop   = q.v0 && out_ready;
    match = in_field.diff < `FCD_MATCH_THR;
    cfree = in_field.comb < `FCD_COMB_THR;
    // A still picture is comb free on every field; only alternation counts
    cadf  = (q.seen != 2'h0) && (cfree != q.prev_cf);
    if (acc) begin
      if (q.seen != `FCD_SEEN_FULL) begin
        d.seen = q.seen + 2'h1;
      end
      // Needs two earlier fields so a same-parity partner exists
      if (EN32 && q.seen == `FCD_SEEN_FULL) begin
        if (match) begin
          // Only exact match-to-match spacing confirms a period
          if (q.have_m && q.gap == `FCD_GAP32) begin
            if (q.per != `FCD_PER32) begin
              per_n = q.per + 2'h1;
            end
          end else begin
            per_n = 2'h0;
          end
          d.per    = per_n;
          d.have_m = 1'b1;
          d.gap    = 3'h0;
          d.miss   = 4'h0;
          if (per_n == `FCD_PER32) begin
            d.lock32 = 1'b1;
          end
        end else begin
          if (q.gap != `FCD_GAP_MAX) begin
            d.gap = q.gap + 3'h1;
          end
          if (q.gap >= `FCD_GAP32) begin
            d.per = 2'h0;
          end
          if (q.miss != `FCD_MISS32) begin
            d.miss = q.miss + 4'h1;
          end
          if (q.miss + 4'h1 == `FCD_MISS32) begin
            d.lock32 = 1'b0;
            d.per    = 2'h0;
          end
        end
      end
      if (EN22) begin
        d.prev_cf = cfree;
        if (cadf) begin
          d.nc = 2'h0;
          if (q.cad != `FCD_LOCK22) begin
            d.cad = q.cad + 3'h1;
          end
          if (q.cad + 3'h1 == `FCD_LOCK22) begin
            d.lock22 = 1'b1;
          end
        end else begin
          d.cad = 3'h0;
          if (q.nc != `FCD_UNLOCK22) begin
            d.nc = q.nc + 2'h1;
          end
          if (q.nc + 2'h1 == `FCD_UNLOCK22) begin
            d.lock22 = 1'b0;
          end
        end
      end
      // 3:2 phase: repeat field and every second field after it weave
      // with the previous one; the others take the two past fields
      nd.parity = in_field.parity;
      nd.lock32 = d.lock32;
      nd.lock22 = d.lock22;
      if (d.lock32) begin
        nd.mode = d.gap[0] ? fcd_pkg::FCD_WEAVE_PAST
                           : fcd_pkg::FCD_WEAVE_CUR;
      end else if (d.lock22) begin
        nd.mode = cfree ? fcd_pkg::FCD_WEAVE_CUR
                        : fcd_pkg::FCD_WEAVE_PAST;
      end else begin
        nd.mode = fcd_pkg::FCD_PASS;
      end
    end
    // Two-entry buffer: a stalled receiver loses no decision
    if (pop) begin
      d.e0 = q.e1;
      d.v0 = q.v1;
      d.v1 = 1'b0;
    end
    if (acc) begin
      if (!d.v0) begin
        d.e0 = nd;
        d.v0 = 1'b1;
      end else begin
        d.e1 = nd;
        d.v1 = 1'b1;
      end
    end
    d.rdy = !d.v1;
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign in_ready  = q.rdy;
  assign out_valid = q.v0;
  assign out_dec   = q.e0;
  assign lock32    = q.lock32;
  assign lock22    = q.lock22;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  AST_UNLOCK32:
    assert property (q.lock32 && acc && !match && q.miss == 4'ha &&
                     q.seen == `FCD_SEEN_FULL |=> !q.lock32)
    else $error("3:2 lock held after eleven mismatches");

  AST_LOCK32_CAUSE:
    assert property ($rose(q.lock32) |-> $past(acc) && $past(match) &&
                     $past(q.gap) == 3'h4)
    else $error("3:2 lock without a five-field spacing match");

  AST_LOCK22:
    assert property (EN22 && acc && cadf && q.cad == 3'h5 |=> q.lock22)
    else $error("2:2 lock missing after six cadenced fields");

  AST_UNLOCK22:
    assert property (EN22 && acc && !cadf && q.nc == 2'h2 |=> !q.lock22)
    else $error("2:2 lock held after three uncadenced fields");

  AST_NO_DETECT:
    assert property (!EN32 |-> !q.lock32 ##1 !q.lock32)
    else $error("3:2 lock while the detector is absent");

  AST_PASS_UNLOCKED:
    assert property (q.v0 && q.e0.mode == fcd_pkg::FCD_PASS |->
                     !q.e0.lock32 && !q.e0.lock22)
    else $error("pass decision issued while locked");

  AST_WEAVE_LOCKED:
    assert property (acc && (d.lock32 || d.lock22) |=>
                     (q.v0 && q.e0.mode != fcd_pkg::FCD_PASS) ||
                     (q.v1 && q.e1.mode != fcd_pkg::FCD_PASS))
    else $error("locked field produced no woven frame");

  AST_HOLD:
    assert property (q.v0 && !out_ready |=> q.v0 && $stable(q.e0))
    else $error("stalled decision changed or dropped");

  AST_FULL_STALL:
    assert property (q.v0 && q.v1 |-> !in_ready)
    else $error("buffer full yet input ready");

  AST_STILL_NO_LOCK:
    assert property (acc && cfree && q.prev_cf && q.seen != 2'h0 |=>
                     q.cad == 3'h0)
    else $error("steady comb-free picture counted as cadence");

  // Buffer bookkeeping: the second slot is only ever filled behind the head
  AST_V1_NEEDS_V0:
    assert property (q.v1 |->
                     q.v0)
    else $error("second buffer slot valid with empty head");

  AST_POP_SHIFT:
    assert property (pop && q.v1 |=>
                     q.v0 && q.e0 == $past(q.e1))
    else $error("queued decision lost on pop");

  AST_FIRST_SLOT:
    assert property (acc && !q.v0 |=>
                     q.v0 && q.e0.parity == $past(in_field.parity))
    else $error("decision for taken field missing at head");

  AST_SECOND_SLOT:
    assert property (acc && q.v0 && !out_ready |=>
                     q.v1 && q.e1.parity == $past(in_field.parity))
    else $error("decision for taken field missing in second slot");

  AST_OUT_DRAINS:
    assert property (pop && !q.v1 && !acc |=>
                     !q.v0)
    else $error("head stays valid after its only decision left");

  AST_LOCK32_MODE:
    assert property (q.v0 && q.e0.lock32 |->
                     q.e0.mode != fcd_pkg::FCD_PASS)
    else $error("3:2 locked decision not woven");

  AST_LOCK22_MODE:
    assert property (q.v0 && q.e0.lock22 |->
                     q.e0.mode != fcd_pkg::FCD_PASS)
    else $error("2:2 locked decision not woven");

  // Counters saturate; a wrap would fake a lock or an unlock
  AST_SEEN_SAT:
    assert property (1'b1 |->
                     q.seen <= `FCD_SEEN_FULL)
    else $error("field history counter past its limit");

  AST_PER_SAT:
    assert property (1'b1 |->
                     q.per <= `FCD_PER32)
    else $error("period counter past its limit");

  AST_MISS_SAT:
    assert property (1'b1 |->
                     q.miss <= `FCD_MISS32)
    else $error("mismatch counter past its limit");

  AST_CAD_SAT:
    assert property (1'b1 |->
                     q.cad <= `FCD_LOCK22)
    else $error("cadenced field counter past its limit");

  AST_NC_SAT:
    assert property (1'b1 |->
                     q.nc <= `FCD_UNLOCK22)
    else $error("uncadenced field counter past its limit");

  AST_MATCH_CLEARS:
    assert property (EN32 && acc && match && q.seen == `FCD_SEEN_FULL |=>
                     q.gap == 3'h0 && q.miss == 4'h0)
    else $error("match did not restart spacing and miss count");

  AST_EARLY_QUIET:
    assert property (acc && q.seen != `FCD_SEEN_FULL |=>
                     $stable(q.lock32))
    else $error("3:2 lock moved without a same-parity partner");

  AST_LOCK32_KEEP:
    assert property (q.lock32 && acc && match |=>
                     q.lock32)
    else $error("3:2 lock dropped on a match");

  AST_LOCK32_FALL:
    assert property ($fell(q.lock32) |->
                     $past(acc) && !$past(match))
    else $error("3:2 lock dropped without a mismatch");

  AST_LOCK22_RISE:
    assert property ($rose(q.lock22) |->
                     $past(acc) && $past(cadf))
    else $error("2:2 lock without a cadenced field");

  AST_LOCK22_FALL:
    assert property ($fell(q.lock22) |->
                     $past(acc) && !$past(cadf))
    else $error("2:2 lock dropped on a cadenced field");

  AST_FIRST_NOT_CAD:
    assert property (EN22 && acc && q.seen == 2'h0 |=>
                     q.cad == 3'h0)
    else $error("first field counted as cadence");

  AST_NO_DETECT22:
    assert property (!EN22 |->
                     !q.lock22)
    else $error("2:2 lock while the detector is absent");

endmodule : fcd_top

// file: test/fcd_src_model.sv
`timescale 1ns/100ps

module fcd_src_model (
  input  wire logic                clk_sys,
  input  wire logic                rstn,
  input  wire logic                in_ready,
  output      logic                in_valid,
  output      fcd_pkg::fcd_field_t in_field
);
  fcd_pkg::fcd_field_t q[$];

  initial begin
    in_valid = 1'b0;
    in_field = '0;
  end

  // Offer is held until taken; an idle bus toggles so stale data never
  // passes for a fresh summary
  always @(posedge clk_sys) begin
    if (!rstn) begin
      in_valid <= 1'b0;
    end else if (!in_valid || in_ready) begin
      if (q.size() > 0) begin
        in_valid <= 1'b1;
        in_field <= q.pop_front();
      end else begin
        in_valid <= 1'b0;
        in_field <= ~in_field;
      end
    end
  end
endmodule : fcd_src_model

// file: test/film_cadence_detector_bench.sv
`timescale 1ns/100ps

module film_cadence_detector_bench;
  logic                clk_sys;
  logic                rstn;
  logic                in_valid;
  logic                in_ready;
  logic                out_valid;
  logic                out_ready;
  logic                lock32;
  logic                lock22;
  fcd_pkg::fcd_field_t in_field;
  fcd_pkg::fcd_dec_t   out_dec;
  fcd_pkg::fcd_dec_t   got[$];
  int                  n_fail;
  int                  compares;
  int                  cyc;
  int                  sent;
  int                  rd_mode;

  fcd_top #(.CADENCE_SEL(2'h3)) dut_u (
    .clk_sys   (clk_sys),
    .rstn      (rstn),
    .in_valid  (in_valid),
    .in_field  (in_field),
    .in_ready  (in_ready),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_dec   (out_dec),
    .lock32    (lock32),
    .lock22    (lock22)
  );

  fcd_src_model src_u (
    .clk_sys  (clk_sys),
    .rstn     (rstn),
    .in_ready (in_ready),
    .in_valid (in_valid),
    .in_field (in_field)
  );

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Stall pattern of mode 2 keeps both buffer slots busy
  always @(posedge clk_sys) begin
    cyc++;
    out_ready <= (rd_mode == 1) || (rd_mode == 2 && cyc % 3 == 0);
    if (rstn && out_valid && out_ready)
      got.push_back(out_dec);
    if (cyc == 5000) begin
      n_fail++;
      stop_test();
    end
  end

  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic do_reset;
    rstn <= 1'b0;
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (2) @(posedge clk_sys);
    got.delete();
    sent = 0;
    check("in_ready", in_ready, 1);
    check("out_valid", out_valid, 0);
    check("locks", {lock32, lock22}, 0);
  endtask : do_reset

  task automatic feed(logic [15:0] diff, logic [15:0] comb);
    src_u.q.push_back({sent[0], diff, comb});
    sent++;
  endtask : feed

  task automatic wait_all;
    while (got.size() < sent) @(posedge clk_sys);
    foreach (got[k]) check("parity", got[k].parity, k[0]);
  endtask : wait_all

  task automatic t_buf;
    do_reset();
    rd_mode = 0;
    repeat (4) feed(16'h0040, 16'h0040);
    repeat (8) @(posedge clk_sys);
    check("in_ready", in_ready, 0);
    check("out_valid", out_valid, 1);
    rd_mode = 1;
    wait_all();
    check("count", got.size(), 4);
    $display("Test buffer done");
  endtask : t_buf

  task automatic t_32;
    do_reset();
    rd_mode = 2;
    for (int k = 0; k < 24; k++)
      feed((k % 5 == 2 && k < 13) ? 16'h0000 : 16'h0040, 16'hffff);
    wait_all();
    check("lock32", got[11].lock32, 0);
    check("lock32", got[12].lock32, 1);
    check("mode", got[12].mode, fcd_pkg::FCD_WEAVE_CUR);
    check("mode", got[13].mode, fcd_pkg::FCD_WEAVE_PAST);
    check("lock32", got[22].lock32, 1);
    check("mode", got[23].mode, fcd_pkg::FCD_PASS);
    check("lock32", lock32, 0);
    $display("Test 3:2 done");
  endtask : t_32

  task automatic t_22;
    logic [15:0] flag;
    flag = 16'h0a95;
    do_reset();
    rd_mode = 1;
    for (int k = 0; k < 16; k++)
      feed(16'h0040, flag[k] ? 16'h003f : 16'h0040);
    wait_all();
    check("lock22", got[5].lock22, 0);
    check("lock22", got[11].lock22, 0);
    check("lock22", got[12].lock22, 1);
    check("mode", got[12].mode, fcd_pkg::FCD_WEAVE_PAST);
    check("lock22", got[14].lock22, 1);
    check("mode", got[15].mode, fcd_pkg::FCD_PASS);
    check("lock22", lock22, 0);
    $display("Test 2:2 done");
  endtask : t_22

  // A still picture is comb free on every field and must never lock
  task automatic t_still;
    do_reset();
    rd_mode = 1;
    repeat (10) feed(16'h0040, 16'h0000);
    wait_all();
    check("lock22", got[9].lock22, 0);
    check("mode", got[9].mode, fcd_pkg::FCD_PASS);
    check("lock22", lock22, 0);
    $display("Test still picture done");
  endtask : t_still

  task automatic stop_test;
    $display("Compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : stop_test

  initial begin
    rstn      = 1'b0;
    out_ready = 1'b0;
    rd_mode   = 1;
    n_fail    = 0;
    compares  = 0;
    cyc       = 0;
    sent      = 0;
    t_buf();
    t_32();
    t_22();
    t_still();
    stop_test();
  end
endmodule : film_cadence_detector_bench
